// ===== rtl/fap_addr_phase.sv
// address and request phase engine of a front side bus agent
// assumes pins are presented as asserted-high logical levels, with the pad
// inverting to the active-low wire; bus clock and bus reset arrive as pins
`timescale 1ns/100ps
module fap_addr_phase
	import fap_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic bclk_pin,
	input wire logic bus_reset_pin_n,
	input wire logic addr_bit20_mask_in,
	input wire fap_pins_t pins_i,
	output fap_pins_t pins_o,
	output fap_pins_t pins_oe,
	input wire logic req_valid,
	input wire fap_request_t req_data,
	output logic req_ready,
	output logic rx_valid,
	output fap_rx_t rx_data,
	output logic cfg_valid,
	output logic [CFG_W-1:0] cfg_word
);

	localparam int TX_SPAN_CYC = 2 * SUBPH_CYC; // whole request on the pins

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic bclk_s1; // sync stage one, read by stage two only
		logic bclk_s2;
		logic bclk_prev;
		logic rst_s1;
		logic rst_s2;
		logic rst_prev;
		logic a20_s1;
		logic a20_s2;
		logic ads_s1;
		logic ads_s2;
		logic [CFG_W-1:0] cfg_s1;
		logic [CFG_W-1:0] cfg_s2;
		fap_tx_state_t fsm;
		logic [CNT_W-1:0] cnt; // cycles into the sub-phase
		logic pend; // request waiting for a bus clock edge
		fap_request_t hold; // request being driven
		fap_pins_t pins_o;
		fap_pins_t pins_oe;
		logic req_ready;
		logic ads_seen; // remote request announced
		logic got_lo;
		logic got_hi;
		logic rx_valid;
		fap_rx_t rx_data;
		logic cfg_valid;
		logic [CFG_W-1:0] cfg_word;
	} fap_state_t;

	fap_state_t s;
	fap_state_t next_s;

	// lane outputs
	logic [LANE_LO_W-1:0] lo_sub1;
	logic [LANE_LO_W-1:0] lo_sub2;
	logic [LANE_HI_W-1:0] hi_sub1;
	logic [LANE_HI_W-1:0] hi_sub2;
	logic lo_done;
	logic hi_done;

	// ---------------------------------------------------------------
	// capture lanes
	// ---------------------------------------------------------------
	// low strobe times type and low bits
	fap_strobe_lane #(.W(LANE_LO_W)) u_lane_lo (
		.clk(clk),
		.reset_n(reset_n),
		.strobe_pin(pins_i.address_source_strobes[0]),
		.data_pin({pins_i.req, pins_i.addr[LO_W-1:0]}),
		.sub1(lo_sub1),
		.sub2(lo_sub2),
		.done(lo_done)
	);

	fap_strobe_lane #(.W(LANE_HI_W)) u_lane_hi (
		.clk(clk),
		.reset_n(reset_n),
		.strobe_pin(pins_i.address_source_strobes[1]),
		.data_pin({pins_i.address_parity_pins, pins_i.addr[ADDR_W-1:LO_W]}),
		.sub1(hi_sub1),
		.sub2(hi_sub2),
		.done(hi_done)
	);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		fap_subphase_t ph;
		fap_subphase_t r1;
		fap_subphase_t r2;
		logic [AP_W-1:0] ap1;
		logic [AP_W-1:0] ap2;
		ph = s.hold.ph1;
		r1 = '0;
		r2 = '0;
		ap1 = '0;
		ap2 = '0;
		next_s = s;
		// synchronisers
		next_s.bclk_s1 = bclk_pin;
		next_s.bclk_s2 = s.bclk_s1;
		next_s.bclk_prev = s.bclk_s2;
		next_s.rst_s1 = bus_reset_pin_n;
		next_s.rst_s2 = s.rst_s1;
		next_s.rst_prev = s.rst_s2;
		next_s.a20_s1 = addr_bit20_mask_in;
		next_s.a20_s2 = s.a20_s1;
		next_s.ads_s1 = pins_i.request_valid_strobe;
		next_s.ads_s2 = s.ads_s1;
		next_s.cfg_s1 = pins_i.addr[CFG_LSB +: CFG_W];
		next_s.cfg_s2 = s.cfg_s1;
		next_s.rx_valid = 1'b0;

		if (s.rst_s2 && !s.rst_prev) begin
			next_s.cfg_valid = 1'b1;
			next_s.cfg_word = s.cfg_s2;
		end

		// accept a new request while nothing is outstanding
		if (req_valid && s.req_ready) begin
			next_s.pend = 1'b1;
			next_s.hold = req_data;
		end

		case (s.fsm)
			TX_IDLE: begin
				// count down the quiet time left after our own drive
				if (s.cnt != '0) begin
					next_s.cnt = s.cnt - 1'b1;
				end
				// launch only on a bus clock rising edge
				if (s.pend && s.bclk_s2 && !s.bclk_prev) begin
					if (s.a20_s2) begin
						ph.addr[A20_IDX] = 1'b0;
					end
					next_s.hold.ph1 = ph;
					next_s.pend = 1'b0;
					next_s.fsm = TX_SUB1;
					next_s.cnt = '0;
					next_s.pins_o.addr = ph.addr;
					next_s.pins_o.req = ph.req;
					next_s.pins_o.request_valid_strobe = 1'b1;
					next_s.pins_o.address_source_strobes = '0;
					next_s.pins_o.address_parity_pins = fap_parity(ph, 1'b0);
					next_s.pins_oe = '1;
				end
			end
			TX_SUB1: begin
				next_s.cnt = s.cnt + 1'b1;
				if (s.cnt == STB_OFS) begin
					next_s.pins_o.address_source_strobes = '1;
				end
				if (s.cnt == SUBPH_LAST) begin
					next_s.fsm = TX_SUB2;
					next_s.cnt = '0;
					next_s.pins_o.addr = s.hold.ph2.addr;
					next_s.pins_o.req = s.hold.ph2.req;
					next_s.pins_o.address_parity_pins = fap_parity(s.hold.ph2, 1'b1);
				end
			end
			TX_SUB2: begin
				next_s.cnt = s.cnt + 1'b1;
				if (s.cnt == STB_OFS) begin
					next_s.pins_o.address_source_strobes = '0;
				end
				if (s.cnt == SUBPH_LAST) begin
					next_s.fsm = TX_IDLE;
					// our strobes still sit in the lane synchronisers: stay deaf a while
					next_s.cnt = SUBPH_LAST;
					next_s.pins_o = '0;
					next_s.pins_oe = '0;
				end
			end
			default: begin
				next_s.fsm = TX_IDLE;
				next_s.pins_o = '0;
				next_s.pins_oe = '0;
			end
		endcase

		// ---------------- receive side ----------------
		// own drive would echo back, so listen only while idle
		if (s.fsm == TX_IDLE && s.cnt == '0) begin
			if (s.ads_s2) begin
				next_s.ads_seen = 1'b1;
			end
			if (lo_done) begin
				next_s.got_lo = 1'b1;
			end
			if (hi_done) begin
				next_s.got_hi = 1'b1;
			end
		end
		if (s.got_lo && s.got_hi) begin
			r1 = {hi_sub1[HI_W-1:0], lo_sub1[LO_W-1:0], lo_sub1[LANE_LO_W-1:LO_W]};
			r2 = {hi_sub2[HI_W-1:0], lo_sub2[LO_W-1:0], lo_sub2[LANE_LO_W-1:LO_W]};
			ap1 = hi_sub1[LANE_HI_W-1:HI_W];
			ap2 = hi_sub2[LANE_HI_W-1:HI_W];
			// strobes without an announced request are dropped
			if (s.ads_seen) begin
				next_s.rx_valid = 1'b1;
				next_s.rx_data.req.ph1 = r1;
				next_s.rx_data.req.ph2 = r2;
				next_s.rx_data.perr = (ap1 != fap_parity(r1, 1'b0)) ||
					(ap2 != fap_parity(r2, 1'b1));
			end
			next_s.ads_seen = 1'b0;
			next_s.got_lo = 1'b0;
			next_s.got_hi = 1'b0;
		end

		next_s.req_ready = !next_s.pend && (next_s.fsm == TX_IDLE);
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign pins_o = s.pins_o;
	assign pins_oe = s.pins_oe;
	assign req_ready = s.req_ready;
	assign rx_valid = s.rx_valid;
	assign rx_data = s.rx_data;
	assign cfg_valid = s.cfg_valid;
	assign cfg_word = s.cfg_word;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_sub2_type;
		@(posedge clk) disable iff (!reset_n)
		$rose(s.fsm == TX_SUB2) |-> (s.pins_o.addr == s.hold.ph2.addr &&
			s.pins_o.req == s.hold.ph2.req);
	endproperty
	a_sub2_type: assert property (p_sub2_type) else $error("second sub-phase data wrong");

	property p_parity;
		@(posedge clk) disable iff (!reset_n)
		s.pins_oe.address_parity_pins[0] |-> (s.pins_o.address_parity_pins ==
			fap_parity(fap_subphase_t'({s.pins_o.addr, s.pins_o.req}), s.fsm == TX_SUB2));
	endproperty
	a_parity: assert property (p_parity) else $error("driven parity wrong");

	property p_cfg;
		@(posedge clk) disable iff (!reset_n)
		(s.rst_s2 && !s.rst_prev) |=> (s.cfg_valid && s.cfg_word == $past(s.cfg_s2));
	endproperty
	a_cfg: assert property (p_cfg) else $error("configuration not sampled");

	property p_a20;
		@(posedge clk) disable iff (!reset_n)
		($rose(s.fsm == TX_SUB1) && $past(s.a20_s2)) |-> !s.pins_o.addr[A20_IDX];
	endproperty
	a_a20: assert property (p_a20) else $error("bit 20 not masked");

	property p_ads_span;
		@(posedge clk) disable iff (!reset_n)
		$rose(s.fsm == TX_SUB1) |-> s.pins_o.request_valid_strobe[*8];
	endproperty
	a_ads_span: assert property (p_ads_span) else $error("address strobe dropped");

	property p_rx_after_ads;
		@(posedge clk) disable iff (!reset_n)
		s.rx_valid |-> $past(s.ads_seen);
	endproperty
	a_rx_after_ads: assert property (p_rx_after_ads) else $error("request without strobe");

	property p_strobes_pair;
		@(posedge clk) disable iff (!reset_n)
		s.pins_o.address_source_strobes[0] == s.pins_o.address_source_strobes[1];
	endproperty
	a_strobes_pair: assert property (p_strobes_pair) else $error("strobes disagree");

	property p_one_bclk;
		@(posedge clk) disable iff (!reset_n)
		$rose(s.fsm == TX_SUB1) |-> ##TX_SPAN_CYC (s.fsm == TX_IDLE && !s.pins_oe.request_valid_strobe);
	endproperty
	a_one_bclk: assert property (p_one_bclk) else $error("request overran bus clock");

endmodule : fap_addr_phase

// ===== rtl/fap_pkg.sv
// shared types, constants and parity helper for the front side bus address phase
// assumes a 100 MHz core clock and pin bundles carried as asserted-high logical values
//
// Functional notes
// - second sub-phase carries transaction type information
// - parity covers address bits 35 down to 3
// - sample configuration pins at reset release
// - mask force clears address bit 20
// - address strobe marks a valid request
// - address strobe starts checks and decode
// - latch on both source strobe edges
// - parity high for even count low
package fap_pkg;

	// ---------------------------------------------------------------
	// pin field widths and positions
	// ---------------------------------------------------------------
	localparam int ADDR_W = 33; // address pins 35 down to 3
	localparam int REQ_W = 5; // request type pins
	localparam int AP_W = 2; // parity pins
	localparam int STB_W = 2; // source strobes
	localparam int A20_IDX = 17; // bit 20 sits at index 20 - 3
	localparam int LO_W = 14; // bits 16..3 ride the low strobe
	localparam int HI_W = ADDR_W - LO_W; // bits 35..17 ride the high strobe
	localparam int GRP_SPLIT = 21; // bits 35..24 start at index 21
	localparam int LANE_LO_W = REQ_W + LO_W;
	localparam int LANE_HI_W = AP_W + HI_W;
	localparam int CFG_LSB = 0; // configuration pins start at bit 3
	localparam int CFG_W = 8; // width of the configuration subset

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ = 100; // core clock rate
	localparam int SUBPH_NS = 50; // longest time of one sub-phase
	// longest time, so round down
	localparam int SUBPH_CYC = (SUBPH_NS * CLK_MHZ) / 1000;
	localparam int STB_OFS_CYC = SUBPH_CYC / 2; // strobe edge mid sub-phase
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] STB_OFS = CNT_W'(STB_OFS_CYC);
	localparam logic [CNT_W-1:0] SUBPH_LAST = CNT_W'(SUBPH_CYC - 1);

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [REQ_W-1:0] req;
		logic request_valid_strobe;
		logic [STB_W-1:0] address_source_strobes;
		logic [AP_W-1:0] address_parity_pins;
	} fap_pins_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [REQ_W-1:0] req;
	} fap_subphase_t;

	typedef struct packed {
		fap_subphase_t ph1; // address and first type
		fap_subphase_t ph2; // type information
	} fap_request_t;

	typedef struct packed {
		fap_request_t req;
		logic perr; // parity mismatch in either sub-phase
	} fap_rx_t;

	typedef enum logic [1:0] {TX_IDLE, TX_SUB1, TX_SUB2} fap_tx_state_t;

	// parity per sub-phase; logical one means pin low, so an odd count
	// of asserted covered lines gives an asserted parity bit
	function automatic logic [AP_W-1:0] fap_parity(input fap_subphase_t s, input logic sub2);
		logic hi;
		logic lo;
		hi = ^s.addr[ADDR_W-1:GRP_SPLIT];
		lo = ^{s.addr[GRP_SPLIT-1:0], s.req};
		fap_parity = sub2 ? {hi, lo} : {lo, hi};
	endfunction : fap_parity

endpackage : fap_pkg

// ===== rtl/fap_strobe_lane.sv
// one source-synchronous capture lane: strobe plus the lines it times
// assumes the strobe and data arrive from the bus, outside the core clock domain
`timescale 1ns/100ps
module fap_strobe_lane
	import fap_pkg::*;
#(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic strobe_pin,
	input wire logic [W-1:0] data_pin,
	output logic [W-1:0] sub1,
	output logic [W-1:0] sub2,
	output logic done
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic stb_s1; // first sync stage, read by stb_s2 only
		logic stb_s2;
		logic stb_prev; // edge finder
		logic [W-1:0] dat_s1;
		logic [W-1:0] dat_s2;
		logic [W-1:0] sub1;
		logic [W-1:0] sub2;
		logic done;
	} fap_lane_state_t;

	fap_lane_state_t s;
	fap_lane_state_t next_s;
	logic assert_edge;
	logic release_edge;

	// data and strobe share sync depth, so their alignment survives
	assign assert_edge = s.stb_s2 & ~s.stb_prev;
	assign release_edge = ~s.stb_s2 & s.stb_prev;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.stb_s1 = strobe_pin;
		next_s.stb_s2 = s.stb_s1;
		next_s.stb_prev = s.stb_s2;
		next_s.dat_s1 = data_pin;
		next_s.dat_s2 = s.dat_s1;
		next_s.done = 1'b0;
		if (assert_edge) begin
			next_s.sub1 = s.dat_s2;
		end
		if (release_edge) begin
			next_s.sub2 = s.dat_s2;
			next_s.done = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign sub1 = s.sub1;
	assign sub2 = s.sub2;
	assign done = s.done;

	property p_lane_first;
		@(posedge clk) disable iff (!reset_n)
		assert_edge |=> (s.sub1 == $past(s.dat_s2));
	endproperty
	a_lane_first: assert property (p_lane_first) else $error("first sub-phase not latched");

	property p_lane_second;
		@(posedge clk) disable iff (!reset_n)
		release_edge |=> (s.done && s.sub2 == $past(s.dat_s2));
	endproperty
	a_lane_second: assert property (p_lane_second) else $error("second sub-phase not latched");

endmodule : fap_strobe_lane

// ===== testbench/fap_far_agent.sv
// far-side bus agent model: resolves the bus wire, captures our requests, sends its own
// assumes logical asserted-high pins; released lines sit at the termination level, logic 0
`timescale 1ns/100ps
module fap_far_agent
	import fap_pkg::*;
(
	input wire logic clk,
	input wire fap_pins_t pins_o,
	input wire fap_pins_t pins_oe,
	output fap_pins_t pins_i
);
	// ---------------------------------------------------------------
	// state and capture queues
	// ---------------------------------------------------------------
	fap_pins_t drv = '0; // our own drive
	logic drv_en = 1'b0; // high while we drive
	logic stb_q = 1'b0; // strobe level last edge
	fap_subphase_t s1_q; // first sub-phase held
	logic [1:0] p1_q; // first parity held
	fap_subphase_t q1[$]; // captured first sub-phases
	fap_subphase_t q2[$]; // captured second sub-phases
	logic [1:0] qp1[$]; // captured parity, first
	logic [1:0] qp2[$]; // captured parity, second

	// undriven lines fall to the pull-up, never hold the last value
	assign pins_i = (pins_o & pins_oe) | (drv & ~pins_oe & {$bits(fap_pins_t){drv_en}});

	// parity per sub-phase; logical one means wire low
	// parity groups
	function automatic logic [1:0] par(input fap_subphase_t s, input logic sub2);
		logic hi;
		logic lo;
		hi = ^s.addr[32:21];
		lo = ^{s.addr[20:0], s.req};
		par = sub2 ? {hi, lo} : {lo, hi};
	endfunction : par

	// both strobes move together here, so one lane edge times both halves
	// capture on strobe edges
	always @(posedge clk) begin
		stb_q <= &pins_i.address_source_strobes;
		if (!drv_en && pins_i.request_valid_strobe && &pins_i.address_source_strobes && !stb_q) begin
			s1_q <= '{pins_i.addr, pins_i.req};
			p1_q <= pins_i.address_parity_pins;
		end
		if (!drv_en && stb_q && !(|pins_i.address_source_strobes)) begin
			q1.push_back(s1_q);
			qp1.push_back(p1_q);
			q2.push_back('{pins_i.addr, pins_i.req});
			qp2.push_back(pins_i.address_parity_pins);
		end
	end

	// hold a static pattern on the pins, e.g. configuration straps
	task automatic hold(input fap_pins_t p, input logic en);
		@(posedge clk);
		drv <= p;
		drv_en <= en;
	endtask : hold

	// one remote request; bad flips a parity bit, ads low sends strobes alone
	// request walk
	task automatic send(input fap_subphase_t s1, input fap_subphase_t s2, input logic ads,
			input logic bad);
		@(posedge clk);
		drv_en <= 1'b1;
		drv <= '{s1.addr, s1.req, ads, 2'b00, par(s1, 1'b0) ^ {1'b0, bad}};
		repeat (2) @(posedge clk);
		drv.address_source_strobes <= 2'b11;
		repeat (3) @(posedge clk);
		drv.addr <= s2.addr;
		drv.req <= s2.req;
		drv.address_parity_pins <= par(s2, 1'b1);
		repeat (2) @(posedge clk);
		drv.address_source_strobes <= 2'b00;
		repeat (3) @(posedge clk);
		drv <= '0;
		drv_en <= 1'b0;
	endtask : send
endmodule : fap_far_agent

// ===== testbench/test_fap_addr_phase.sv
// self-checking bench for the address phase engine against a far-side agent model
// assumes 100 MHz core clock and a free bus clock pin of 125 ns
`timescale 1ns/100ps
module test_fap_addr_phase
	import fap_pkg::*;
;
	// ---------------------------------------------------------------
	// stimulus and observation
	// ---------------------------------------------------------------
	logic clk = 1'b0; // core clock
	logic bclk_pin = 1'b0; // bus clock, phase unrelated
	logic reset_n = 1'b0; // core reset
	logic bus_reset_pin_n = 1'b0; // bus reset pin
	logic addr_bit20_mask_in = 1'b0; // mask input
	logic req_valid = 1'b0; // request offer
	fap_request_t req_data = '0; // request payload
	fap_pins_t pins_i; // resolved wire
	fap_pins_t pins_o; // our drive
	fap_pins_t pins_oe; // our enables
	logic req_ready; // idle flag
	logic rx_valid; // remote request pulse
	fap_rx_t rx_data; // remote request
	logic cfg_valid; // config captured
	logic [CFG_W-1:0] cfg_word; // config value
	int mismatches = 0; // failed compares
	int n_compared = 0; // all compares
	int n_rx = 0; // remote request pulses seen
	fap_request_t exp_q[$]; // model of requests in flight

	always #5 clk = ~clk;
	always #62.5 bclk_pin = ~bclk_pin;

	// count remote pulses away from the launching edge
	always @(negedge clk) begin
		if (rx_valid === 1'b1) begin
			n_rx++;
		end
	end

	fap_addr_phase uut (.clk(clk), .reset_n(reset_n), .bclk_pin(bclk_pin),
		.bus_reset_pin_n(bus_reset_pin_n), .addr_bit20_mask_in(addr_bit20_mask_in),
		.pins_i(pins_i), .pins_o(pins_o), .pins_oe(pins_oe), .req_valid(req_valid),
		.req_data(req_data), .req_ready(req_ready), .rx_valid(rx_valid), .rx_data(rx_data),
		.cfg_valid(cfg_valid), .cfg_word(cfg_word));

	fap_far_agent partner (.clk(clk), .pins_o(pins_o), .pins_oe(pins_oe), .pins_i(pins_i));

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// one edge, then let its updates land
	task automatic tick;
		@(posedge clk);
		#1;
	endtask : tick

	function automatic logic [95:0] rnd;
		rnd = {$urandom, $urandom, $urandom};
	endfunction : rnd

	task automatic chk_v(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_v

	task automatic chk_sub(input string nm, input fap_subphase_t e, input fap_subphase_t g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_sub

	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results

	// offer one request; a later junk offer while busy must be ignored
	task automatic issue(input fap_request_t r);
		int k;
		logic [95:0] j;
		for (k = 0; k < 100 && req_ready !== 1'b1; k++) tick;
		j = rnd();
		req_valid <= 1'b1;
		req_data <= r;
		tick;
		req_valid <= 1'b0;
		repeat (3) tick;
		req_valid <= 1'b1;
		req_data <= j[75:0];
		repeat (2) tick;
		req_valid <= 1'b0;
	endtask : issue

	// watchdog cuts a hang short
	initial begin
		#300000;
		mismatches++;
		results;
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		fap_request_t r;
		fap_subphase_t e1;
		fap_subphase_t s1;
		fap_subphase_t s2;
		fap_pins_t p;
		logic [95:0] t;
		logic m;
		logic seen;
		int k;
		int i;
		t = $urandom(87);
		repeat (5) tick;
		reset_n <= 1'b1;
		tick;
		// configuration straps at bus reset release
		t = rnd();
		p = '0;
		p.addr[7:0] = t[7:0];
		partner.hold(p, 1'b1);
		repeat (3) tick;
		bus_reset_pin_n <= 1'b1;
		repeat (8) tick;
		chk_v("cfg_valid", 8'h01, cfg_valid);
		chk_v("cfg_word", t[7:0], cfg_word);
		partner.hold('0, 1'b0);
		// outgoing requests, mask both ways, one at a time
		for (i = 0; i < 12; i++) begin
			t = rnd();
			r = t[75:0];
			m = (i < 2) ? i[0] : t[80];
			addr_bit20_mask_in <= m;
			repeat (5) tick;
			exp_q.push_back(r);
			issue(r);
			for (k = 0; k < 200 && partner.q2.size() == 0; k++) tick;
			r = exp_q.pop_front();
			e1 = r.ph1;
			if (m) begin
				e1.addr[A20_IDX] = 1'b0;
			end
			chk_v("captured", 8'h01, 8'(partner.q2.size()));
			chk_sub("tx_ph1", e1, partner.q1.pop_front());
			chk_sub("tx_ph2", r.ph2, partner.q2.pop_front());
			chk_v("tx_par1", partner.par(e1, 1'b0), partner.qp1.pop_front());
			chk_v("tx_par2", partner.par(r.ph2, 1'b1), partner.qp2.pop_front());
		end
		addr_bit20_mask_in <= 1'b0;
		repeat (40) tick;
		chk_v("extra_captures", 8'h00, 8'(partner.q2.size()));
		chk_v("echo_rx", 8'h00, 8'(n_rx));
		// remote requests; last three carry a parity fault, final one lacks ads
		for (i = 0; i < 7; i++) begin
			t = rnd();
			s1 = t[37:0];
			s2 = t[75:38];
			for (k = 0; k < 100 && req_ready !== 1'b1; k++) tick;
			partner.send(s1, s2, i < 6, i >= 4);
			seen = 1'b0;
			for (k = 0; k < 30 && seen !== 1'b1; k++) begin
				tick;
				seen = rx_valid;
			end
			chk_v("rx_valid", (i < 6) ? 8'h01 : 8'h00, seen);
			if (i < 6) begin
				chk_sub("rx_ph1", s1, rx_data.req.ph1);
				chk_sub("rx_ph2", s2, rx_data.req.ph2);
				chk_v("rx_perr", (i >= 4) ? 8'h01 : 8'h00, rx_data.perr);
			end
		end
		chk_v("rx_count", 8'h06, 8'(n_rx));
		results;
	end
endmodule : test_fap_addr_phase
